// ==== design/irq_ctrl_pkg.sv ====
// Overview of operation
// - sixteen external request pins, each with its own control register.
// - each pin selects low level, falling, rising or both-edge detection.
// - optional per-pin digital noise filter with enable and sample-rate registers.
// - peripheral requests use a fixed edge or level detection per source.
// - two software sources raise a request when their register is written.
// - every vector has a priority register; arbitration picks the highest level.
// - one vector may be marked fast for a shorter processor response.
// - vectors 26 and up route to the transfer engine when their bit is set.
// - each DMA channel holds a register naming its activating vector.
// - non-maskable pin triggers on a chosen edge, optionally filtered.
// - oscillator stop, watchdogs and both voltage monitors raise non-maskable requests.
// - RAM parity error raises a non-maskable request.
// - non-maskable sources have flag and enable; every flag has a clear bit.
// - any pending source ends sleep mode.
// - clock-stop mode wakes on pins, monitors, oscillator, RTC, independent watchdog, remote, 146-157.
// - standby wakes on the same set minus oscillator stop and configurable vectors.
// - deep standby wakes on non-maskable pin, chosen pins, monitors or RTC.
// - groups BL0, BL1, BL2 and AL0 each have request and enable registers.
// - configurable vectors 128-255 take their source from select registers.
// - request registers collect configurable type B and type A requests.
// - a write protect register blocks writes to the configurable source selects.
package irq_ctrl_pkg;

  localparam int NUM_VEC = 256;
  localparam int NUM_PINS = 16;
  localparam int NUM_DMA = 4;
  localparam int NUM_CFG = 128;

  localparam logic [11:0] ADDR_ROUTE_PAGE = 12'h0100;
  localparam logic [11:0] ADDR_MISC_PAGE = 12'h0200;
  localparam logic [11:0] ADDR_CFG_SEL_PAGE = 12'h0300;
  localparam logic [11:0] ADDR_FILT_EN = 12'h0210;
  localparam logic [11:0] ADDR_FILT_SET = 12'h0211;
  localparam logic [11:0] ADDR_SOFT_ONE = 12'h0212;
  localparam logic [11:0] ADDR_SOFT_TWO = 12'h0213;
  localparam logic [11:0] ADDR_NM_STATUS = 12'h0214;
  localparam logic [11:0] ADDR_NM_ENABLE = 12'h0215;
  localparam logic [11:0] ADDR_NM_CLEAR = 12'h0216;
  localparam logic [11:0] ADDR_NM_PIN_CTRL = 12'h0217;
  localparam logic [11:0] ADDR_FAST = 12'h0218;
  localparam logic [11:0] ADDR_GRP_REQ_BASE = 12'h0219;
  localparam logic [11:0] ADDR_GRP_EN_BASE = 12'h021D;
  localparam logic [11:0] ADDR_CFG_B_REQ_BASE = 12'h0221;
  localparam logic [11:0] ADDR_CFG_A_REQ_BASE = 12'h0223;
  localparam logic [11:0] ADDR_SEL_LOCK = 12'h0225;
  localparam logic [11:0] ADDR_DMA_SEL_BASE = 12'h0226;
  localparam logic [11:0] ADDR_DEEP_PINS = 12'h022A;
  localparam logic [11:0] ADDR_CPU_STATUS = 12'h022B;

  localparam int VEC_ROUTE_MIN = 26;
  localparam int VEC_SOFT_ONE = 27;
  localparam int VEC_SOFT_TWO = 28;
  localparam int VEC_PERIPH_BASE = 32;
  localparam int VEC_PIN_BASE = 64;
  localparam int VEC_GROUP_BASE = 110;
  localparam int VEC_CFG_BASE = 128;
  localparam int VEC_CFG_B_BASE = 144;
  localparam int VEC_CFG_A_BASE = 208;
  localparam int VEC_WAKE_CFG_LO = 146;
  localparam int VEC_WAKE_CFG_HI = 157;

  localparam logic [31:0] PERIPH_LEVEL_MASK = 32'h0000_00F0;
  localparam int PERIPH_RTC_ALARM = 0;
  localparam int PERIPH_RTC_CYCLE = 1;
  localparam int PERIPH_REMOTE = 2;

  localparam int NM_PIN = 0;
  localparam int NM_OSC = 1;
  localparam int NM_WDT = 2;
  localparam int NM_INDEPENDENT_WATCHDOG = 3;
  localparam int NM_VOLTAGE_MONITOR_ONE = 4;
  localparam int NM_VOLTAGE_MONITOR_TWO = 5;
  localparam int NM_RAM = 6;

  localparam logic [1:0] MODE_LOW = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h1;
  localparam logic [1:0] MODE_RISE = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  localparam logic [2:0] DIV8_MASK = 3'h7;
  localparam logic [4:0] DIV32_MASK = 5'h1F;
  localparam logic [5:0] DIV64_MASK = 6'h3F;

  localparam logic PIN_IDLE = 1'h1;
  localparam logic [3:0] PRIO_RESET = 4'h0;
  localparam logic UNLOCK_RESET = 1'h0;

  typedef enum logic [4:0] {
    LP_RUN = 5'h01,
    LP_SLEEP = 5'h02,
    LP_CLK_STOP = 5'h04,
    LP_STANDBY = 5'h08,
    LP_DEEP = 5'h10
  } lp_mode_e;

endpackage

// ==== design/mcu_interrupt_controller.sv ====
`timescale 1ns/1ps
module mcu_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [15:0] ext_irq_pin_in,
  input wire logic nmi_pin_in,
  input wire logic [31:0] periph_req_in,
  input wire logic [31:0] group_bl0_in,
  input wire logic [31:0] group_bl1_in,
  input wire logic [31:0] group_bl2_in,
  input wire logic [31:0] group_al0_in,
  input wire logic [63:0] cfg_pool_in,
  input wire logic osc_stop_in,
  input wire logic wdt_err_in,
  input wire logic independent_watchdog_err_in,
  input wire logic volt_mon_one_in,
  input wire logic volt_mon_two_in,
  input wire logic ram_parity_err_in,
  input wire lp_mode_e power_mode_in,
  output logic cpu_req_out,
  output logic [7:0] cpu_vector_out,
  output logic [3:0] cpu_level_out,
  output logic cpu_fast_out,
  input wire logic cpu_ack_in,
  output logic nmi_req_out,
  output logic xfer_req_out,
  output logic [7:0] xfer_vector_out,
  input wire logic xfer_ack_in,
  output logic [3:0] dma_req_out,
  input wire logic [3:0] dma_ack_in,
  output logic wakeup_out
);

  typedef struct packed {
    logic [255:0][3:0] prio;
    logic [255:0] route;
    logic [255:0] pend;
    logic [15:0][1:0] pin_mode;
    logic [15:0] flt_en;
    logic [31:0] flt_set;
    logic [15:0][1:0] pin_samp;
    logic [15:0] pin_filt;
    logic [31:0] periph_prev;
    logic [3:0] nmi_ctrl;
    logic [1:0] nmi_samp;
    logic nmi_filt;
    logic [6:0] nm_status;
    logic [6:0] nm_enable;
    logic [7:0] fast_vec;
    logic fast_en;
    logic [3:0][31:0] grp_en;
    logic [127:0][5:0] cfg_sel;
    logic unlock;
    logic [3:0][7:0] dma_sel;
    logic [15:0] deep_pins;
    logic [5:0] div_cnt;
    logic [31:0] rdata;
    logic cpu_req;
    logic [7:0] cpu_vec;
    logic [3:0] cpu_lvl;
    logic cpu_fast;
    logic xfer_req;
    logic [7:0] xfer_vec;
    logic [3:0] dma_req;
    logic wake;
  } state_s;

  state_s s;
  state_s next_s;

  // sample-rate enable taken from the shared free-running divider
  function automatic logic rate_hit(input logic [1:0] sel, input logic [5:0] cnt);
    logic hit;
    hit = 1'b1;
    case (sel)
      2'h0: hit = 1'b1;
      2'h1: hit = (cnt[2:0] & DIV8_MASK) == 3'h0;
      2'h2: hit = (cnt[4:0] & DIV32_MASK) == 5'h00;
      default: hit = (cnt & DIV64_MASK) == 6'h00;
    endcase
    return hit;
  endfunction

  // returns {samples, filtered}; three equal samples in a row move the output
  function automatic logic [2:0] filt_step(input logic en, input logic hit, input logic [1:0] samp,
                                           input logic filt, input logic pin);
    logic [2:0] res;
    res = {samp, filt};
    if (!en) begin
      res = {pin, pin, pin};
    end else if (hit) begin
      res = {samp[0], pin, ((samp[1] == samp[0]) && (samp[0] == pin)) ? pin : filt};
    end
    return res;
  endfunction

  // highest level wins, lowest vector on a tie; level zero never wins
  function automatic logic [8:0] pick(input logic [255:0] req, input logic [255:0][3:0] pr);
    logic [8:0] best;
    logic [3:0] lvl;
    best = 9'h000;
    lvl = 4'h0;
    for (int v = 0; v < NUM_VEC; v++) begin
      if (req[v] && (pr[v] > lvl)) begin
        best = {1'b1, 8'(v)};
        lvl = pr[v];
      end
    end
    return best;
  endfunction

  logic [255:0] raw;
  logic [255:0] dma_claim;
  logic [255:0] cpu_cand;
  logic [8:0] cpu_pick;
  logic [8:0] xfer_pick;
  logic [2:0] fstep;
  logic [15:0] pin_edge;
  logic nmi_edge;
  logic [31:0] periph_rise;
  logic [3:0][31:0] grp_src;
  logic [3:0] addr_lo;
  logic pins_any;
  logic pins_deep;
  logic cfg_wake;
  logic common_wake;

  assign grp_src[0] = group_bl0_in;
  assign grp_src[1] = group_bl1_in;
  assign grp_src[2] = group_bl2_in;
  assign grp_src[3] = group_al0_in;

  always_comb begin
    next_s = s;
    next_s.rdata = 32'h0000_0000;
    next_s.div_cnt = s.div_cnt + 6'h01;
    addr_lo = reg_addr_in[3:0];
    raw = s.pend;
    dma_claim = '0;
    pin_edge = '0;

    for (int i = 0; i < NUM_PINS; i++) begin
      fstep = filt_step(s.flt_en[i], rate_hit(s.flt_set[2*i +: 2], s.div_cnt), s.pin_samp[i],
                        s.pin_filt[i], ext_irq_pin_in[i]);
      next_s.pin_samp[i] = fstep[2:1];
      next_s.pin_filt[i] = fstep[0];
      case (s.pin_mode[i])
        MODE_FALL: pin_edge[i] = s.pin_filt[i] & ~fstep[0];
        MODE_RISE: pin_edge[i] = ~s.pin_filt[i] & fstep[0];
        MODE_BOTH: pin_edge[i] = s.pin_filt[i] ^ fstep[0];
        default: pin_edge[i] = 1'b0;
      endcase
      if (s.pin_mode[i] == MODE_LOW) begin
        raw[VEC_PIN_BASE + i] = ~s.pin_filt[i];
      end
    end

    fstep = filt_step(s.nmi_ctrl[1], rate_hit(s.nmi_ctrl[3:2], s.div_cnt), s.nmi_samp, s.nmi_filt,
                      nmi_pin_in);
    next_s.nmi_samp = fstep[2:1];
    next_s.nmi_filt = fstep[0];
    nmi_edge = s.nmi_ctrl[0] ? (~s.nmi_filt & fstep[0]) : (s.nmi_filt & ~fstep[0]);

    next_s.periph_prev = periph_req_in;
    periph_rise = periph_req_in & ~s.periph_prev & ~PERIPH_LEVEL_MASK;
    for (int k = 0; k < 32; k++) begin
      raw[VEC_PERIPH_BASE + k] = s.pend[VEC_PERIPH_BASE + k] | (periph_req_in[k] & PERIPH_LEVEL_MASK[k]);
    end
    for (int g = 0; g < 4; g++) begin
      raw[VEC_GROUP_BASE + g] = |(grp_src[g] & s.grp_en[g]);
    end
    for (int j = 0; j < NUM_CFG; j++) begin
      raw[VEC_CFG_BASE + j] = cfg_pool_in[s.cfg_sel[j]];
    end

    // acceptance clears the edge request presented in the same cycle as the acknowledge
    if (cpu_ack_in && s.cpu_req) begin
      next_s.pend[s.cpu_vec] = 1'b0;
    end
    if (xfer_ack_in && s.xfer_req) begin
      next_s.pend[s.xfer_vec] = 1'b0;
    end
    for (int m = 0; m < NUM_DMA; m++) begin
      if (dma_ack_in[m] && s.dma_req[m]) begin
        next_s.pend[s.dma_sel[m]] = 1'b0;
      end
    end

    // new events land after the clears, so a set in the clear cycle survives
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_edge[i]) begin
        next_s.pend[VEC_PIN_BASE + i] = 1'b1;
      end
    end
    for (int k = 0; k < 32; k++) begin
      if (periph_rise[k]) begin
        next_s.pend[VEC_PERIPH_BASE + k] = 1'b1;
      end
    end

    if (reg_wr_in) begin
      if (reg_addr_in[11:8] == 4'h0) begin
        next_s.prio[reg_addr_in[7:0]] = reg_wdata_in[3:0];
      end else if (reg_addr_in[11:8] == ADDR_ROUTE_PAGE[11:8]) begin
        if (reg_addr_in[7:0] >= 8'(VEC_ROUTE_MIN)) begin
          next_s.route[reg_addr_in[7:0]] = reg_wdata_in[0];
        end
      end else if (reg_addr_in[11:8] == ADDR_CFG_SEL_PAGE[11:8]) begin
        if (!reg_addr_in[7] && s.unlock) begin
          next_s.cfg_sel[reg_addr_in[6:0]] = reg_wdata_in[5:0];
        end
      end else if (reg_addr_in[11:4] == ADDR_MISC_PAGE[11:4]) begin
        next_s.pin_mode[addr_lo] = reg_wdata_in[1:0];
      end else begin
        case (reg_addr_in)
          ADDR_FILT_EN: next_s.flt_en = reg_wdata_in[15:0];
          ADDR_FILT_SET: next_s.flt_set = reg_wdata_in;
          ADDR_SOFT_ONE: next_s.pend[VEC_SOFT_ONE] = next_s.pend[VEC_SOFT_ONE] | reg_wdata_in[0];
          ADDR_SOFT_TWO: next_s.pend[VEC_SOFT_TWO] = next_s.pend[VEC_SOFT_TWO] | reg_wdata_in[0];
          ADDR_NM_ENABLE: next_s.nm_enable = reg_wdata_in[6:0];
          ADDR_NM_CLEAR: next_s.nm_status = s.nm_status & ~reg_wdata_in[6:0];
          ADDR_NM_PIN_CTRL: next_s.nmi_ctrl = reg_wdata_in[3:0];
          ADDR_FAST: begin
            next_s.fast_vec = reg_wdata_in[7:0];
            next_s.fast_en = reg_wdata_in[8];
          end
          ADDR_SEL_LOCK: next_s.unlock = reg_wdata_in[0];
          ADDR_DEEP_PINS: next_s.deep_pins = reg_wdata_in[15:0];
          default: begin
            if (reg_addr_in >= ADDR_GRP_EN_BASE && reg_addr_in < ADDR_CFG_B_REQ_BASE) begin
              next_s.grp_en[2'(reg_addr_in - ADDR_GRP_EN_BASE)] = reg_wdata_in;
            end
            if (reg_addr_in >= ADDR_DMA_SEL_BASE && reg_addr_in < ADDR_DEEP_PINS) begin
              next_s.dma_sel[2'(reg_addr_in - ADDR_DMA_SEL_BASE)] = reg_wdata_in[7:0];
            end
          end
        endcase
      end
    end

    // the flag write clear happens above, so these sets win in the same cycle
    next_s.nm_status[NM_PIN] = next_s.nm_status[NM_PIN] | nmi_edge;
    next_s.nm_status[NM_OSC] = next_s.nm_status[NM_OSC] | osc_stop_in;
    next_s.nm_status[NM_WDT] = next_s.nm_status[NM_WDT] | wdt_err_in;
    next_s.nm_status[NM_INDEPENDENT_WATCHDOG] = next_s.nm_status[NM_INDEPENDENT_WATCHDOG] | independent_watchdog_err_in;
    next_s.nm_status[NM_VOLTAGE_MONITOR_ONE] = next_s.nm_status[NM_VOLTAGE_MONITOR_ONE] | volt_mon_one_in;
    next_s.nm_status[NM_VOLTAGE_MONITOR_TWO] = next_s.nm_status[NM_VOLTAGE_MONITOR_TWO] | volt_mon_two_in;
    next_s.nm_status[NM_RAM] = next_s.nm_status[NM_RAM] | ram_parity_err_in;

    if (reg_rd_in) begin
      if (reg_addr_in[11:8] == 4'h0) begin
        next_s.rdata = 32'(s.prio[reg_addr_in[7:0]]);
      end else if (reg_addr_in[11:8] == ADDR_ROUTE_PAGE[11:8]) begin
        next_s.rdata = 32'(s.route[reg_addr_in[7:0]]);
      end else if (reg_addr_in[11:8] == ADDR_CFG_SEL_PAGE[11:8]) begin
        next_s.rdata = reg_addr_in[7] ? 32'h0000_0000 : 32'(s.cfg_sel[reg_addr_in[6:0]]);
      end else if (reg_addr_in[11:4] == ADDR_MISC_PAGE[11:4]) begin
        next_s.rdata = 32'(s.pin_mode[addr_lo]);
      end else begin
        case (reg_addr_in)
          ADDR_FILT_EN: next_s.rdata = 32'(s.flt_en);
          ADDR_FILT_SET: next_s.rdata = s.flt_set;
          ADDR_NM_STATUS: next_s.rdata = 32'(s.nm_status);
          ADDR_NM_ENABLE: next_s.rdata = 32'(s.nm_enable);
          ADDR_NM_PIN_CTRL: next_s.rdata = 32'(s.nmi_ctrl);
          ADDR_FAST: next_s.rdata = 32'({s.fast_en, s.fast_vec});
          ADDR_CFG_B_REQ_BASE: next_s.rdata = raw[VEC_CFG_B_BASE +: 32];
          ADDR_CFG_B_REQ_BASE + 12'h001: next_s.rdata = raw[VEC_CFG_B_BASE + 32 +: 32];
          ADDR_CFG_A_REQ_BASE: next_s.rdata = raw[VEC_CFG_A_BASE +: 32];
          ADDR_CFG_A_REQ_BASE + 12'h001: next_s.rdata = 32'(raw[VEC_CFG_A_BASE + 32 +: 16]);
          ADDR_SEL_LOCK: next_s.rdata = 32'(s.unlock);
          ADDR_DEEP_PINS: next_s.rdata = 32'(s.deep_pins);
          ADDR_CPU_STATUS: next_s.rdata = 32'({s.cpu_req, s.cpu_fast, s.cpu_lvl, s.cpu_vec});
          default: begin
            if (reg_addr_in >= ADDR_GRP_REQ_BASE && reg_addr_in < ADDR_GRP_EN_BASE) begin
              next_s.rdata = grp_src[2'(reg_addr_in - ADDR_GRP_REQ_BASE)];
            end
            if (reg_addr_in >= ADDR_GRP_EN_BASE && reg_addr_in < ADDR_CFG_B_REQ_BASE) begin
              next_s.rdata = s.grp_en[2'(reg_addr_in - ADDR_GRP_EN_BASE)];
            end
            if (reg_addr_in >= ADDR_DMA_SEL_BASE && reg_addr_in < ADDR_DEEP_PINS) begin
              next_s.rdata = 32'(s.dma_sel[2'(reg_addr_in - ADDR_DMA_SEL_BASE)]);
            end
          end
        endcase
      end
    end

    // a vector named by a DMA channel goes to that channel unless its route bit sends it to the transfer engine, never to the processor
    for (int m = 0; m < NUM_DMA; m++) begin
      next_s.dma_req[m] = (s.dma_sel[m] != 8'h00) && raw[s.dma_sel[m]] && !s.route[s.dma_sel[m]];
      if (s.dma_sel[m] != 8'h00) begin
        dma_claim[s.dma_sel[m]] = 1'b1;
      end
    end
    cpu_cand = raw & ~s.route & ~dma_claim;
    cpu_pick = pick(cpu_cand, s.prio);
    xfer_pick = pick(raw & s.route, s.prio);
    if (s.fast_en && cpu_cand[s.fast_vec]) begin
      cpu_pick = {1'b1, s.fast_vec};
    end
    next_s.cpu_req = cpu_pick[8];
    next_s.cpu_vec = cpu_pick[7:0];
    next_s.cpu_lvl = s.prio[cpu_pick[7:0]];
    next_s.cpu_fast = cpu_pick[8] && s.fast_en && (cpu_pick[7:0] == s.fast_vec);
    next_s.xfer_req = xfer_pick[8];
    next_s.xfer_vec = xfer_pick[7:0];

    pins_any = |raw[VEC_PIN_BASE +: 16];
    pins_deep = |(raw[VEC_PIN_BASE +: 16] & s.deep_pins);
    cfg_wake = |raw[VEC_WAKE_CFG_HI:VEC_WAKE_CFG_LO];
    common_wake = s.nm_status[NM_PIN] | pins_any | s.nm_status[NM_VOLTAGE_MONITOR_ONE] | s.nm_status[NM_VOLTAGE_MONITOR_TWO]
                  | raw[VEC_PERIPH_BASE + PERIPH_RTC_ALARM] | raw[VEC_PERIPH_BASE + PERIPH_RTC_CYCLE]
                  | s.nm_status[NM_INDEPENDENT_WATCHDOG] | raw[VEC_PERIPH_BASE + PERIPH_REMOTE];
    case (power_mode_in)
      LP_SLEEP: next_s.wake = (|raw) | (|s.nm_status);
      LP_CLK_STOP: next_s.wake = common_wake | s.nm_status[NM_OSC] | cfg_wake;
      LP_STANDBY: next_s.wake = common_wake;
      LP_DEEP: next_s.wake = s.nm_status[NM_PIN] | pins_deep | s.nm_status[NM_VOLTAGE_MONITOR_ONE]
                             | s.nm_status[NM_VOLTAGE_MONITOR_TWO] | raw[VEC_PERIPH_BASE + PERIPH_RTC_ALARM]
                             | raw[VEC_PERIPH_BASE + PERIPH_RTC_CYCLE];
      default: next_s.wake = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s <= '0;
      s.prio <= {NUM_VEC{PRIO_RESET}};
      s.pin_samp <= '1;
      s.pin_filt <= {NUM_PINS{PIN_IDLE}};
      s.nmi_samp <= '1;
      s.nmi_filt <= PIN_IDLE;
      s.unlock <= UNLOCK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign cpu_req_out = s.cpu_req;
  assign cpu_vector_out = s.cpu_vec;
  assign cpu_level_out = s.cpu_lvl;
  assign cpu_fast_out = s.cpu_fast;
  assign nmi_req_out = |(s.nm_status & s.nm_enable);
  assign xfer_req_out = s.xfer_req;
  assign xfer_vector_out = s.xfer_vec;
  assign dma_req_out = s.dma_req;
  assign wakeup_out = s.wake;

endmodule

// ==== sim/irq_ctrl_sva.sv ====
`timescale 1ns/1ps
module irq_ctrl_sva
  import irq_ctrl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic nmi_pin_in,
  input wire logic osc_stop_in,
  input wire logic wdt_err_in,
  input wire logic independent_watchdog_err_in,
  input wire logic volt_mon_one_in,
  input wire logic volt_mon_two_in,
  input wire logic ram_parity_err_in,
  input wire lp_mode_e power_mode_in,
  input wire logic cpu_req_out,
  input wire logic [7:0] cpu_vector_out,
  input wire logic [3:0] cpu_level_out,
  input wire logic cpu_fast_out,
  input wire logic cpu_ack_in,
  input wire logic nmi_req_out,
  input wire logic xfer_req_out,
  input wire logic [7:0] xfer_vector_out,
  input wire logic xfer_ack_in,
  input wire logic wakeup_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  wire soft_wr = reg_wr_in && reg_addr_in == ADDR_SOFT_ONE && reg_wdata_in[0];
  wire clr_all = reg_wr_in && reg_addr_in == ADDR_NM_CLEAR && reg_wdata_in[6:0] == 7'h7F;
  wire nm_quiet = !(osc_stop_in | wdt_err_in | independent_watchdog_err_in | volt_mon_one_in | volt_mon_two_in | ram_parity_err_in);
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  a_nmi_clear_all: assert property (clr_all && nm_quiet && $stable(nmi_pin_in) |=> !nmi_req_out)
    else $error("nmi request survived a full clear");
  a_level_nonzero: assert property (cpu_req_out && !cpu_fast_out |-> cpu_level_out != 4'h0)
    else $error("priority zero vector presented");
  a_fast_needs_req: assert property (cpu_fast_out |-> cpu_req_out)
    else $error("fast flag without request");
  a_xfer_vec_min: assert property (xfer_req_out |-> xfer_vector_out >= 8'h1A)
    else $error("transfer request below routable range");
  a_one_target: assert property (xfer_req_out && cpu_req_out |-> xfer_vector_out != cpu_vector_out)
    else $error("vector sent to both processor and transfer engine");
  a_sleep_wake: assert property ((soft_wr && power_mode_in == LP_SLEEP) ##1 (power_mode_in == LP_SLEEP) [*2]
    |-> ##[0:1] wakeup_out)
    else $error("sleep not ended by pending source");
  a_clkstop_osc_wake: assert property ((osc_stop_in && power_mode_in == LP_CLK_STOP)
    ##1 (power_mode_in == LP_CLK_STOP) [*2] |-> ##[0:1] wakeup_out)
    else $error("clock stop not ended by oscillator stop");
  c_cpu_ack: cover property (cpu_ack_in && cpu_req_out);
  c_xfer_ack: cover property (xfer_ack_in && xfer_req_out);
  c_nmi_rise: cover property ($rose(nmi_req_out));
endmodule

// ==== sim/core_model.sv ====
`timescale 1ns/1ps
module core_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hold_in,
  input wire logic req_in,
  input wire logic [7:0] vec_in,
  output logic ack_out
);
  logic [7:0] seen_q[$];
  // one ack pulse, then a quiet cycle so the next vector has settled
  always @(posedge clk_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
    end else if (ack_out) begin
      if (req_in) seen_q.push_back(vec_in);
      ack_out <= 1'b0;
    end else begin
      ack_out <= req_in && !hold_in;
    end
  end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import irq_ctrl_pkg::*; ;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] reg_addr_in = 12'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] ext_irq_pin_in = 16'hFFFF;
  logic nmi_pin_in = 1'b1;
  logic [31:0] periph_req_in = 32'h0;
  logic [31:0] group_bl0_in = 32'h0;
  logic [31:0] group_bl1_in = 32'h0;
  logic [31:0] group_bl2_in = 32'h0;
  logic [31:0] group_al0_in = 32'h0;
  logic [63:0] cfg_pool_in = 64'h0;
  logic [5:0] nm_src = 6'h0;
  lp_mode_e power_mode_in = LP_RUN;
  logic [3:0] dma_ack_in = 4'h0;
  logic cpu_hold = 1'b0;
  logic [31:0] reg_rdata_out;
  logic cpu_req_out, cpu_fast_out, cpu_ack_in, nmi_req_out, xfer_req_out, xfer_ack_in, wakeup_out;
  logic [7:0] cpu_vector_out, xfer_vector_out;
  logic [3:0] cpu_level_out, dma_req_out;
  int fail_count = 0;
  int n_compared = 0;
  int pv[9][2] = '{'{12'h01B, 5}, '{12'h01C, 9}, '{12'h080, 7}, '{12'h06E, 4}, '{12'h043, 3}, '{12'h045, 2},
    '{ADDR_SEL_LOCK, 1}, '{12'h300, 5}, '{12'h020, 6}};

  always #5 clk_sys_in = ~clk_sys_in;

  mcu_interrupt_controller uut (.clk_sys_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .ext_irq_pin_in, .nmi_pin_in, .periph_req_in, .group_bl0_in, .group_bl1_in, .group_bl2_in,
    .group_al0_in, .cfg_pool_in, .osc_stop_in(nm_src[0]), .wdt_err_in(nm_src[1]), .independent_watchdog_err_in(nm_src[2]),
    .volt_mon_one_in(nm_src[3]), .volt_mon_two_in(nm_src[4]), .ram_parity_err_in(nm_src[5]), .power_mode_in,
    .cpu_req_out, .cpu_vector_out, .cpu_level_out, .cpu_fast_out, .cpu_ack_in, .nmi_req_out, .xfer_req_out,
    .xfer_vector_out, .xfer_ack_in, .dma_req_out, .dma_ack_in, .wakeup_out);
  core_model cpu_m (.clk_in(clk_sys_in), .rst_in(sys_rst_in), .hold_in(cpu_hold), .req_in(cpu_req_out),
    .vec_in(cpu_vector_out), .ack_out(cpu_ack_in));
  core_model xfer_m (.clk_in(clk_sys_in), .rst_in(sys_rst_in), .hold_in(1'b0), .req_in(xfer_req_out),
    .vec_in(xfer_vector_out), .ack_out(xfer_ack_in));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(reg_rdata_out, e);
  endtask
  // waits on the core models, so a lost ack shows up as a wrong count, not a hang
  task automatic wait_n(input int n);
    repeat (300) if (cpu_m.seen_q.size() + xfer_m.seen_q.size() < n) @(posedge clk_sys_in);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd_chk(12'h01B, 32'h0);
    rd_chk(ADDR_NM_STATUS, 32'h0);
    rd_chk(12'h400, 32'h0);
    wr(12'h300, 32'h5);
    rd_chk(12'h300, 32'h0);
    wr(12'h10A, 32'h1);
    rd_chk(12'h10A, 32'h0);
    foreach (pv[i]) wr(12'(pv[i][0]), 32'(pv[i][1]));
    rd_chk(12'h300, 32'h5);
    cpu_hold <= 1'b1;
    wr(ADDR_SOFT_ONE, 32'h1);
    wr(ADDR_SOFT_TWO, 32'h1);
    settle();
    chk({cpu_level_out, cpu_vector_out}, 32'h91C);
    cpu_hold <= 1'b0;
    wait_n(2);
    chk({cpu_m.seen_q[0], cpu_m.seen_q[1]}, 32'h1C1B);
    cpu_m.seen_q.delete();
    wr(ADDR_FAST, 32'h11B);
    cpu_hold <= 1'b1;
    wr(ADDR_SOFT_TWO, 32'h1);
    wr(ADDR_SOFT_ONE, 32'h1);
    settle();
    chk({cpu_fast_out, cpu_vector_out}, 32'h11B);
    cpu_hold <= 1'b0;
    wait_n(2);
    cpu_m.seen_q.delete();
    wr(ADDR_FAST, 32'h0);
    wr(12'h11C, 32'h1);
    wr(ADDR_SOFT_TWO, 32'h1);
    wait_n(1);
    chk({8'(cpu_m.seen_q.size()), xfer_m.seen_q[0]}, 32'h1C);
    xfer_m.seen_q.delete();
    wr(12'h11C, 32'h0);
    wr(ADDR_DMA_SEL_BASE, 32'h1B);
    wr(ADDR_SOFT_ONE, 32'h1);
    settle();
    chk(dma_req_out, 32'h1);
    dma_ack_in <= 4'h1;
    @(posedge clk_sys_in);
    dma_ack_in <= 4'h0;
    settle();
    chk({dma_req_out, 8'(cpu_m.seen_q.size())}, 32'h0);
    wr(ADDR_DMA_SEL_BASE, 32'h0);
    wr(12'h203, 32'h1);
    ext_irq_pin_in[3] <= 1'b0;
    wait_n(1);
    chk(cpu_m.seen_q[0], 32'h43);
    ext_irq_pin_in[3] <= 1'b1;
    cpu_m.seen_q.delete();
    cpu_hold <= 1'b1;
    @(posedge clk_sys_in);
    ext_irq_pin_in[5] <= 1'b0;
    settle();
    chk(cpu_vector_out, 32'h45);
    ext_irq_pin_in[5] <= 1'b1;
    settle();
    chk(cpu_req_out, 32'h0);
    wr(ADDR_GRP_EN_BASE, 32'h1);
    group_bl0_in[0] <= 1'b1;
    cfg_pool_in[5] <= 1'b1;
    rd_chk(ADDR_GRP_REQ_BASE, 32'h1);
    // level sources stay presented until dropped, so the core is held and the order read off the outputs
    settle();
    chk({cpu_level_out, cpu_vector_out}, 32'h780);
    cfg_pool_in[5] <= 1'b0;
    settle();
    chk({cpu_level_out, cpu_vector_out}, 32'h46E);
    group_bl0_in[0] <= 1'b0;
    settle();
    chk(cpu_req_out, 32'h0);
    cpu_hold <= 1'b0;
    wr(ADDR_NM_ENABLE, 32'h7E);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_in);
      nm_src[i] <= 1'b1;
      @(posedge clk_sys_in);
      nm_src[i] <= 1'b0;
      @(negedge clk_sys_in);
      chk(nmi_req_out, 32'h1);
      rd_chk(ADDR_NM_STATUS, 32'h2 << i);
      wr(ADDR_NM_CLEAR, 32'h2 << i);
      rd_chk(ADDR_NM_STATUS, 32'h0);
    end
    nmi_pin_in <= 1'b0;
    rd_chk(ADDR_NM_STATUS, 32'h1);
    nmi_pin_in <= 1'b1;
    wr(ADDR_NM_CLEAR, 32'h7F);
    for (int m = 0; m < 2; m++) begin
      power_mode_in <= m ? LP_CLK_STOP : LP_STANDBY;
      @(posedge clk_sys_in);
      nm_src[0] <= 1'b1;
      @(posedge clk_sys_in);
      nm_src[0] <= 1'b0;
      settle();
      chk(wakeup_out, 32'(m));
      wr(ADDR_NM_CLEAR, 32'h7F);
    end
    power_mode_in <= LP_SLEEP;
    wr(ADDR_SOFT_ONE, 32'h1);
    repeat (2) @(negedge clk_sys_in);
    chk(wakeup_out, 32'h1);
    wait_n(1);
    power_mode_in <= LP_RUN;
    cpu_m.seen_q.delete();
    periph_req_in[0] <= 1'b1;
    wait_n(1);
    settle();
    chk({cpu_req_out, cpu_m.seen_q[0]}, 32'h20);
    close_out();
  end
endmodule

bind mcu_interrupt_controller irq_ctrl_sva chk_u (.clk_sys_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .nmi_pin_in, .osc_stop_in, .wdt_err_in, .independent_watchdog_err_in, .volt_mon_one_in,
  .volt_mon_two_in, .ram_parity_err_in, .power_mode_in, .cpu_req_out, .cpu_vector_out, .cpu_level_out,
  .cpu_fast_out, .cpu_ack_in, .nmi_req_out, .xfer_req_out, .xfer_vector_out, .xfer_ack_in, .wakeup_out);
